/* File: pkg/logic_eval_pkg.sv */
package logic_eval_pkg;

  localparam int TABLE_LEN = 512;
  localparam int IDX_W = 10;
  localparam int NUM_TIMERS = 32;
  localparam int DLY_W = 16;
  localparam int MAX_GATE_IN = 16;

  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  localparam int S_PER_MIN = 60;

  localparam int DEFAULT_GROUPS = 6;
  localparam int GROUP_LEN = 4;
  localparam int DEFAULT_TRIP_BASE = 0;

  typedef enum logic [4:0] {
    OP_END = 5'h00,
    OP_ON = 5'h01,
    OP_OFF = 5'h02,
    OP_ELEM = 5'h03,
    OP_VIN = 5'h04,
    OP_CIN = 5'h05,
    OP_VOUT = 5'h06,
    OP_RSTCMD = 5'h07,
    OP_NOT = 5'h08,
    OP_AND = 5'h09,
    OP_OR = 5'h0A,
    OP_XOR = 5'h0B,
    OP_NAND = 5'h0C,
    OP_NOR = 5'h0D,
    OP_LATCH = 5'h0E,
    OP_TIMER = 5'h0F,
    OP_ASSIGN = 5'h10
  } op_t;

  typedef struct packed {
    op_t op;
    logic [8:0] arg;
  } entry_t;

  typedef enum logic [1:0] {
    ED_WRITE = 2'h0,
    ED_INSERT = 2'h1,
    ED_DELETE = 2'h2,
    ED_DEFAULT = 2'h3
  } edit_cmd_t;

  typedef enum logic [1:0] {
    TB_MS = 2'h0,
    TB_SEC = 2'h1,
    TB_MIN = 2'h2
  } timebase_t;

  typedef struct packed {
    timebase_t base;
    logic [DLY_W-1:0] pickup;
    logic [DLY_W-1:0] dropout;
  } timer_cfg_t;

  typedef struct packed {
    edit_cmd_t cmd;
    logic [IDX_W-1:0] index;
    entry_t entry;
  } edit_req_t;

  typedef enum logic [1:0] {
    ST_EVAL = 2'b00,
    ST_WRAP = 2'b01
  } eval_state_t;

endpackage

/* File: design/postfix_logic_evaluator.sv */
// What this block does
// - Table of 512 entries, numbered from 1, holding the default table after reset.
// - A pass stops at the first terminator; later entries are ignored.
// - Flags of disabled elements read as 0, never 1.
// - A virtual output may be read before its assignment in the pass.
// - Constant true and constant false operands exist.
// - Insert and delete shift following entries to open or close a gap.
// - 32 timers act as operators on the preceding result.
// - Each timer selects the time unit of its delays.
// - Timer asserts after input true for pickup delay; zero passes at once.
// - Timer clears after input false for dropout delay; zero clears at once.
// - Default table: six latch groups in entries 1-24, terminator at 25.
// - Timer outputs feed later operators like any result.
// - Gates combine their stated count of preceding results; NOT takes one.
// - Latch: preceding result is reset, the one before it is set.
// - Assignment stores the preceding result in the numbered virtual output.
// - A full pass completes at least 4 times per power cycle.
module postfix_logic_evaluator
  import logic_eval_pkg::*;
#(
  parameter int NUM_ELEM = 64,
  parameter int NUM_VIN = 32,
  parameter int NUM_CIN = 32,
  parameter int NUM_VOUT = 64,
  parameter int NUM_TMR = NUM_TIMERS,
  parameter int STACK_DEPTH = 32,
  parameter int MS_DIV = MS_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [NUM_ELEM-1:0] element_state,
  input wire logic [NUM_ELEM-1:0] element_enable,
  input wire logic [NUM_VIN-1:0] virtual_input,
  input wire logic [NUM_CIN-1:0] contact_input,
  input wire logic reset_command_operand,
  input wire timer_cfg_t [NUM_TMR-1:0] timer_cfg,
  input wire logic edit_valid,
  input wire edit_req_t edit_req,
  output logic [NUM_VOUT-1:0] virtual_output,
  output logic [NUM_TMR-1:0] timer_output,
  output logic pass_done,
  output logic eval_error
);

  localparam int SPW = $clog2(STACK_DEPTH + 1);
  localparam int PCW = $clog2(TABLE_LEN);
  localparam int MSW = 16;

  if (NUM_ELEM > 512 || NUM_VIN > 512 || NUM_CIN > 512 ||
      NUM_VOUT > 512 || NUM_TMR > 512 || NUM_TMR < 1 ||
      STACK_DEPTH < MAX_GATE_IN || MS_DIV < 2 ||
      MS_DIV > 65536) begin : g_bad_param
    $error("postfix_logic_evaluator: unsupported parameter value");
  end

  typedef struct packed {
    entry_t [TABLE_LEN-1:0] eqn;
    logic [TABLE_LEN-1:0] latch_q;
    logic [STACK_DEPTH-1:0] stk;
    logic [SPW-1:0] sp;
    logic [PCW-1:0] pc;
    eval_state_t state;
    logic [NUM_VOUT-1:0] vout;
    logic [NUM_TMR-1:0] tin;
    logic [NUM_TMR-1:0] tout;
    logic [NUM_TMR-1:0][DLY_W-1:0] tcnt;
    logic [MSW-1:0] ms_cnt;
    logic [9:0] s_cnt;
    logic [5:0] min_cnt;
    logic err_acc;
    logic err_last;
    logic pass_done;
  } state_t;

  state_t q;
  state_t n;

  function automatic logic [TABLE_LEN-1:0][$bits(entry_t)-1:0]
      default_table();
    logic [TABLE_LEN-1:0][$bits(entry_t)-1:0] t;
    t = '0;
    for (int g = 0; g < DEFAULT_GROUPS; g++) begin
      t[g*GROUP_LEN] = {OP_ELEM, 9'(DEFAULT_TRIP_BASE + g)};
      t[g*GROUP_LEN+1] = {OP_RSTCMD, 9'h000};
      t[g*GROUP_LEN+2] = {OP_LATCH, 9'h000};
      t[g*GROUP_LEN+3] = {OP_ASSIGN, 9'(g)};
    end
    return t;
  endfunction

  always_comb begin
    entry_t e;
    int sp_i;
    int cnt;
    int idx;
    logic tick_ms;
    logic tick_s;
    logic tick_min;
    logic tk;
    logic [DLY_W-1:0] dly;
    logic opnd;
    logic v_and;
    logic v_or;
    logic v_xor;
    logic res;
    logic set_in;
    logic rst_in;
    e = q.eqn[q.pc];
    sp_i = int'(q.sp);
    cnt = 0;
    idx = 0;
    tk = 1'b0;
    dly = '0;
    opnd = 1'b0;
    v_and = 1'b1;
    v_or = 1'b0;
    v_xor = 1'b0;
    res = 1'b0;
    set_in = 1'b0;
    rst_in = 1'b0;
    n = q;
    n.pass_done = 1'b0;

    // Shared time bases: one enable pulse per ms, s and min
    tick_ms = (int'(q.ms_cnt) == MS_DIV - 1);
    tick_s = tick_ms && (int'(q.s_cnt) == MS_PER_S - 1);
    tick_min = tick_s && (int'(q.min_cnt) == S_PER_MIN - 1);
    n.ms_cnt = tick_ms ? '0 : q.ms_cnt + 1'b1;
    if (tick_ms) begin
      n.s_cnt = tick_s ? '0 : q.s_cnt + 1'b1;
    end
    if (tick_s) begin
      n.min_cnt = tick_min ? '0 : q.min_cnt + 1'b1;
    end

    // Timers run on wall time, not on pass count, so delays do not
    // depend on table length
    for (int i = 0; i < NUM_TMR; i++) begin
      case (timer_cfg[i].base)
        TB_SEC: tk = tick_s;
        TB_MIN: tk = tick_min;
        default: tk = tick_ms;
      endcase
      dly = q.tin[i] ? timer_cfg[i].pickup : timer_cfg[i].dropout;
      if (q.tin[i] == q.tout[i]) begin
        n.tcnt[i] = '0;
      end else if (dly == '0) begin
        n.tout[i] = q.tin[i];
        n.tcnt[i] = '0;
      end else if (tk) begin
        if (q.tcnt[i] + 1'b1 >= dly) begin
          n.tout[i] = q.tin[i];
          n.tcnt[i] = '0;
        end else begin
          n.tcnt[i] = q.tcnt[i] + 1'b1;
        end
      end
    end

    case (q.state)
      ST_EVAL: begin
        idx = int'(e.arg);
        case (e.op)
          OP_NOT, OP_TIMER, OP_ASSIGN: cnt = 1;
          OP_LATCH: cnt = 2;
          OP_AND, OP_OR, OP_XOR, OP_NAND, OP_NOR: begin
            cnt = int'(e.arg[4:0]);
          end
          default: cnt = 0;
        endcase
        case (e.op)
          OP_ON: opnd = 1'b1;
          OP_OFF: opnd = 1'b0;
          OP_ELEM: begin
            if (idx < NUM_ELEM) begin
              opnd = element_state[idx] && element_enable[idx];
            end
          end
          OP_VIN: opnd = (idx < NUM_VIN) ? virtual_input[idx] : 1'b0;
          OP_CIN: opnd = (idx < NUM_CIN) ? contact_input[idx] : 1'b0;
          // Reads the stored value: last pass if not yet assigned
          OP_VOUT: opnd = (idx < NUM_VOUT) ? q.vout[idx] : 1'b0;
          OP_RSTCMD: opnd = reset_command_operand;
          default: opnd = 1'b0;
        endcase
        // Combine the top cnt stack entries
        for (int j = 0; j < STACK_DEPTH; j++) begin
          if (j >= sp_i - cnt && j < sp_i) begin
            v_and = v_and & q.stk[j];
            v_or = v_or | q.stk[j];
            v_xor = v_xor ^ q.stk[j];
          end
        end
        if (sp_i >= 1) begin
          rst_in = q.stk[sp_i-1];
        end
        if (sp_i >= 2) begin
          set_in = q.stk[sp_i-2];
        end
        case (e.op)
          OP_NOT: res = ~v_and;
          OP_AND: res = v_and;
          OP_OR: res = v_or;
          OP_XOR: res = v_xor;
          OP_NAND: res = ~v_and;
          OP_NOR: res = ~v_or;
          OP_LATCH: res = ~rst_in & (set_in | q.latch_q[q.pc]);
          OP_TIMER: res = (idx < NUM_TMR) ? q.tout[idx] : 1'b0;
          default: res = opnd;
        endcase
        if (e.op == OP_END) begin
          n.state = ST_WRAP;
        end else if (cnt > sp_i || (cnt == 0 && sp_i == STACK_DEPTH) ||
                     (e.op != OP_NOT && e.op != OP_TIMER &&
                      e.op != OP_ASSIGN && e.op != OP_LATCH &&
                      e.op >= OP_AND && cnt < 2)) begin
          // Malformed entry: flag it and leave the stack alone
          n.err_acc = 1'b1;
        end else if (e.op == OP_ASSIGN) begin
          if (idx < NUM_VOUT) begin
            n.vout[idx] = q.stk[sp_i-1];
          end
          n.sp = SPW'(sp_i - 1);
        end else begin
          if (e.op == OP_LATCH) begin
            n.latch_q[q.pc] = res;
          end
          if (e.op == OP_TIMER && idx < NUM_TMR) begin
            n.tin[idx] = q.stk[sp_i-1];
          end
          n.stk[sp_i-cnt] = res;
          n.sp = SPW'(sp_i - cnt + 1);
        end
        if (e.op != OP_END) begin
          if (int'(q.pc) == TABLE_LEN - 1) begin
            n.state = ST_WRAP;
          end else begin
            n.pc = q.pc + 1'b1;
          end
        end
      end
      ST_WRAP: begin
        // One cycle per entry at 50 ns keeps a full pass far inside a
        // quarter power cycle
        n.pc = '0;
        n.sp = '0;
        n.state = ST_EVAL;
        n.pass_done = 1'b1;
        n.err_last = q.err_acc;
        n.err_acc = 1'b0;
      end
      default: begin
        n.state = ST_WRAP;
      end
    endcase

    // Editing restarts the pass so the stack never mixes two tables
    if (edit_valid && edit_req.cmd == ED_DEFAULT) begin
      n.eqn = default_table();
      n.pc = '0;
      n.sp = '0;
      n.state = ST_EVAL;
      // An aborted pass neither ends with a pulse nor reports its faults
      n.pass_done = 1'b0;
      n.err_acc = 1'b0;
    end else if (edit_valid && edit_req.index != '0 &&
                 int'(edit_req.index) <= TABLE_LEN) begin
      idx = int'(edit_req.index) - 1;
      for (int k = 0; k < TABLE_LEN; k++) begin
        case (edit_req.cmd)
          ED_INSERT: begin
            if (k > idx) begin
              n.eqn[k] = q.eqn[k-1];
            end else if (k == idx) begin
              n.eqn[k] = edit_req.entry;
            end
          end
          ED_DELETE: begin
            if (k >= idx && k < TABLE_LEN - 1) begin
              n.eqn[k] = q.eqn[k+1];
            end else if (k == TABLE_LEN - 1) begin
              n.eqn[k] = '{op: OP_END, arg: '0};
            end
          end
          default: begin
            if (k == idx) begin
              n.eqn[k] = edit_req.entry;
            end
          end
        endcase
      end
      n.pc = '0;
      n.sp = '0;
      n.state = ST_EVAL;
      n.pass_done = 1'b0;
      n.err_acc = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.eqn <= default_table();
    end else begin
      q <= n;
    end
  end

  assign virtual_output = q.vout;
  assign timer_output = q.tout;
  assign pass_done = q.pass_done;
  assign eval_error = q.err_last;

endmodule

/* File: verif/logic_eval_monitor.sv */
module logic_eval_monitor
  import logic_eval_pkg::*;
#(
  parameter int NUM_ELEM = 64,
  parameter int NUM_VIN = 32,
  parameter int NUM_CIN = 32,
  parameter int NUM_VOUT = 64,
  parameter int NUM_TMR = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [NUM_ELEM-1:0] element_state,
  input wire logic [NUM_ELEM-1:0] element_enable,
  input wire logic [NUM_VIN-1:0] virtual_input,
  input wire logic [NUM_CIN-1:0] contact_input,
  input wire logic reset_command_operand,
  input wire timer_cfg_t [NUM_TMR-1:0] timer_cfg,
  input wire logic edit_valid,
  input wire edit_req_t edit_req,
  input wire logic [NUM_VOUT-1:0] virtual_output,
  input wire logic [NUM_TMR-1:0] timer_output,
  input wire logic pass_done,
  input wire logic eval_error
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [9:0] gap_ff;
  logic [6:0] hold_ff;
  // Gap restarts on edits too, since an edit restarts the pass silently
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gap_ff <= 10'h000;
      hold_ff <= 7'h00;
    end else begin
      gap_ff <= (pass_done || edit_valid) ? 10'h000 : gap_ff + 10'h001;
      if (!reset_command_operand) hold_ff <= 7'h00;
      else if (hold_ff != 7'h7f) hold_ff <= hold_ff + 7'h01;
    end
  end
  AST_PD_PULSE: assert property (pass_done |=> !pass_done)
    else $error("pass_done longer than one cycle");
  AST_PD_GAP: assert property (gap_ff <= 10'h202)
    else $error("pass took longer than the full table");
  AST_EDIT_RESTART: assert property (edit_valid &&
    (edit_req.cmd == ED_DEFAULT || (edit_req.index != 10'h000 &&
    edit_req.index <= 10'h200)) |=> !pass_done)
    else $error("pass_done right after an edit");
  AST_FIRST_PASS: assert property ($fell(reset) |-> ##[26:27] pass_done)
    else $error("default table pass length wrong");
  AST_RESET_CLR: assert property (disable iff (1'b0)
    reset && $past(reset) |->
    virtual_output == '0 && timer_output == '0)
    else $error("outputs not clear in reset");
  AST_NO_ERR: assert property (!eval_error)
    else $error("error flag on a balanced table");
  AST_RST_LATCH: assert property (hold_ff == 7'h3c |->
    virtual_output[5:0] == 6'h00)
    else $error("latches not cleared by reset operand");
  AST_DISABLED: assert property (!element_enable[1] |->
    !virtual_output[1])
    else $error("disabled element reached a latch");
  cover property (hold_ff == 7'h3c);
  cover property (virtual_output[7] && virtual_output[8]);
  cover property (edit_valid ##1 !edit_valid);
endmodule

/* File: verif/testbench.sv */
module testbench
  import logic_eval_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [63:0] st, en, ev, got;
  logic [31:0] vin, cin;
  logic rc, edit_valid;
  edit_req_t edit_req;
  timer_cfg_t [31:0] tcfg;
  logic [63:0] vo;
  logic [31:0] tmo;
  logic pd, err;
  logic [63:0] q[$];
  int mismatches = 0;
  int checked = 0;
  postfix_logic_evaluator #(.MS_DIV(20)) u_postfix_logic_evaluator (
    .clk(clk), .reset(reset), .element_state(st), .element_enable(en),
    .virtual_input(vin), .contact_input(cin), .reset_command_operand(rc),
    .timer_cfg(tcfg), .edit_valid(edit_valid), .edit_req(edit_req),
    .virtual_output(vo), .timer_output(tmo), .pass_done(pd),
    .eval_error(err));
  initial forever #25 clk = ~clk;
  always @(negedge clk) begin
    if (pd === 1'b1 && q.size() > 0) begin
      got = q.pop_front();
      `CHK(vo, got)
    end
  end
  task wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task wait_pass(input int n);
    int t;
    repeat (n) begin
      t = 0;
      do begin
        @(negedge clk);
        t++;
      end while (pd !== 1'b1 && t < 600);
      if (t >= 600) begin
        mismatches++;
        wrap_up();
      end
    end
  endtask
  // Two passes first: a timer pushes its previous output, so one lags
  task expect_vo(input logic [63:0] v);
    int t;
    wait_pass(2);
    @(posedge clk);
    q.push_back(v);
    t = 0;
    while (q.size() > 0 && t < 600) begin
      @(negedge clk);
      t++;
    end
    if (t >= 600) begin
      mismatches++;
      wrap_up();
    end
  endtask
  task ed(input edit_cmd_t c, input logic [9:0] i, input op_t o,
          input logic [8:0] a);
    @(negedge clk);
    edit_valid = 1'b1;
    edit_req = '{c, i, '{o, a}};
    @(negedge clk);
    edit_valid = 1'b0;
  endtask
  initial begin
    void'($urandom(32'h0000_f67e));
    st = '0;
    en = '1;
    en[1] = 1'b0;
    vin = '0;
    rc = 1'b0;
    edit_valid = 1'b0;
    edit_req = '0;
    ev = '0;
    cin = $urandom;
    tcfg = '0;
    tcfg[0].base = timebase_t'($urandom_range(2));
    repeat (16) @(negedge clk);
    reset = 1'b0;
    expect_vo(ev);
    st = {$urandom, $urandom};
    ev[5:0] = st[5:0] & en[5:0];
    expect_vo(ev);
    st = '0;
    expect_vo(ev);
    rc = 1'b1;
    ev[5:0] = 6'h00;
    expect_vo(ev);
    rc = 1'b0;
    vin = $urandom;
    ed(ED_WRITE, 10'h001, OP_VIN, 9'h000);
    ed(ED_WRITE, 10'h002, OP_TIMER, 9'h000);
    ed(ED_WRITE, 10'h003, OP_ASSIGN, 9'h007);
    ed(ED_WRITE, 10'h004, OP_ON, 9'h000);
    ed(ED_WRITE, 10'h005, OP_ASSIGN, 9'h008);
    ed(ED_WRITE, 10'h006, OP_CIN, 9'h000);
    ed(ED_WRITE, 10'h007, OP_NOT, 9'h000);
    ed(ED_WRITE, 10'h008, OP_VIN, 9'h001);
    ed(ED_WRITE, 10'h009, OP_AND, 9'h002);
    ed(ED_WRITE, 10'h00a, OP_ASSIGN, 9'h009);
    ed(ED_WRITE, 10'h00b, OP_OFF, 9'h000);
    ed(ED_WRITE, 10'h00c, OP_CIN, 9'h001);
    ed(ED_WRITE, 10'h00d, OP_XOR, 9'h002);
    ed(ED_WRITE, 10'h00e, OP_VIN, 9'h002);
    ed(ED_WRITE, 10'h00f, OP_NAND, 9'h002);
    ed(ED_WRITE, 10'h010, OP_ASSIGN, 9'h00a);
    ed(ED_WRITE, 10'h011, OP_VIN, 9'h003);
    ed(ED_WRITE, 10'h012, OP_CIN, 9'h002);
    ed(ED_WRITE, 10'h013, OP_NOR, 9'h002);
    ed(ED_WRITE, 10'h014, OP_ASSIGN, 9'h00b);
    ed(ED_WRITE, 10'h015, OP_CIN, 9'h003);
    ed(ED_WRITE, 10'h016, OP_VIN, 9'h000);
    ed(ED_WRITE, 10'h017, OP_OR, 9'h002);
    ed(ED_WRITE, 10'h018, OP_ASSIGN, 9'h00c);
    ed(ED_WRITE, 10'h019, OP_END, 9'h000);
    ed(ED_WRITE, 10'h000, OP_END, 9'h000);
    ev[7] = vin[0];
    ev[8] = 1'b1;
    ev[9] = ~cin[0] & vin[1];
    ev[10] = ~(cin[1] & vin[2]);
    ev[11] = ~(vin[3] | cin[2]);
    ev[12] = cin[3] | vin[0];
    expect_vo(ev);
    `CHK(tmo[0], vin[0])
    ed(ED_INSERT, 10'h001, OP_END, 9'h000);
    vin = ~vin;
    expect_vo(ev);
    ed(ED_DELETE, 10'h001, OP_END, 9'h000);
    ev[7] = vin[0];
    ev[9] = ~cin[0] & vin[1];
    ev[10] = ~(cin[1] & vin[2]);
    ev[11] = ~(vin[3] | cin[2]);
    ev[12] = cin[3] | vin[0];
    expect_vo(ev);
    `CHK(tmo[0], vin[0])
    ed(ED_DEFAULT, 10'h000, OP_END, 9'h000);
    expect_vo(ev);
    wrap_up();
  end
endmodule
bind postfix_logic_evaluator logic_eval_monitor #(
  .NUM_ELEM(NUM_ELEM), .NUM_VIN(NUM_VIN), .NUM_CIN(NUM_CIN),
  .NUM_VOUT(NUM_VOUT), .NUM_TMR(NUM_TMR)
) u_logic_eval_monitor (
  .clk(clk), .reset(reset), .element_state(element_state),
  .element_enable(element_enable), .virtual_input(virtual_input),
  .contact_input(contact_input),
  .reset_command_operand(reset_command_operand), .timer_cfg(timer_cfg),
  .edit_valid(edit_valid), .edit_req(edit_req),
  .virtual_output(virtual_output), .timer_output(timer_output),
  .pass_done(pass_done), .eval_error(eval_error));
